//--- rtl/pat_cfg.svh
`ifndef PAT_CFG_SVH
`define PAT_CFG_SVH
// How it works
// - top four address bits pick one entry
// - six-bit page replaces four-bit logical page
// - physical space wider than the logical space
// - segment load fills all sixteen entries
// - segment store returns all sixteen words
// - one eight-bit window constant for all timers
// - translation clears page timer, counts one unit
// - interval end bumps one timer, advances pointer
// - page timers are six bits wide
// - system-only page faults user translation
// - read-only page faults user write
// - no protection checks outside user mode
// - translated write sets modified bit
// - load request clears table position to zero
// - fault withholds the memory strobe
// - interval counter preloaded with inverted constant
`define PAT_ENTRIES 16
`define PAT_PAGE_LSB 0
`define PAT_PAGE_W 6
`define PAT_SYS_BIT 6
`define PAT_RO_BIT 7
`define PAT_MOD_BIT 8
`define PAT_TMR_LSB 9
`define PAT_TMR_W 6
`define PAT_OFS_W 12
`define PAT_RST_ENTRY 16'h0000
`define PAT_RST_WINDOW 8'h00
`define PAT_CNT_FULL 8'hff
`endif

//--- rtl/pat_interval.sv
`include "pat_cfg.svh"
module pat_interval (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // window constant load
  input wire logic load_en,
  input wire logic [7:0] load_value,
  // one pulse per counted translation
  input wire logic tick,
  // timer service
  output logic bump,
  output pat_pkg::pat_idx_t bump_idx,
  output logic armed
);
  logic [7:0] window;
  logic [7:0] count;
  logic first;
  pat_pkg::pat_idx_t ptr;
  logic [7:0] next_window;
  logic [7:0] next_count;
  logic next_first;
  logic next_armed;
  pat_pkg::pat_idx_t next_ptr;
  logic next_bump;
  pat_pkg::pat_idx_t next_bump_idx;

  always_comb
  begin
    next_window = window;
    next_count = count;
    next_first = first;
    next_armed = armed;
    next_ptr = ptr;
    next_bump = 1'b0;
    next_bump_idx = bump_idx;
    if (load_en)
    begin
      next_window = load_value;
      next_armed = 1'b1;
      next_first = 1'b1;
    end
    else if (tick && armed)
    begin
      if (first)
      begin
        next_count = ~window;
        next_first = 1'b0;
      end
      else if (count + 8'h01 == `PAT_CNT_FULL)
      begin
        next_count = ~window;
        next_bump = 1'b1;
        next_bump_idx = ptr;
        next_ptr = ptr + 4'h1;
      end
      else
      begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      window <= `PAT_RST_WINDOW;
      count <= 8'h00;
      first <= 1'b0;
      armed <= 1'b0;
      ptr <= 4'h0;
      bump <= 1'b0;
      bump_idx <= 4'h0;
    end
    else
    begin
      window <= next_window;
      count <= next_count;
      first <= next_first;
      armed <= next_armed;
      ptr <= next_ptr;
      bump <= next_bump;
      bump_idx <= next_bump_idx;
    end
  end
endmodule

//--- rtl/pat_pkg.sv
package pat_pkg;
  typedef logic [15:0] pat_entry_t;
  typedef logic [3:0] pat_idx_t;
  typedef logic [5:0] pat_page_t;
  typedef logic [5:0] pat_timer_t;
  typedef logic [17:0] pat_paddr_t;
  typedef enum logic [1:0] {pat_idle, pat_load, pat_store, pat_xlate} pat_state_t;
endpackage

//--- rtl/pat_table.sv
`include "pat_cfg.svh"
module pat_table (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // table access
  pat_tbl_if.table_side tbl
);
  pat_pkg::pat_entry_t mem [`PAT_ENTRIES];
  pat_pkg::pat_entry_t next_mem [`PAT_ENTRIES];

  // six-bit timer field, wraps on overflow
  function automatic pat_pkg::pat_entry_t bump_timer(input pat_pkg::pat_entry_t e);
    pat_pkg::pat_timer_t t;
    t = e[`PAT_TMR_LSB +: `PAT_TMR_W] + 6'h01;
    bump_timer = e;
    bump_timer[`PAT_TMR_LSB +: `PAT_TMR_W] = t;
  endfunction

  assign tbl.rd_data = mem[tbl.rd_idx];

  always_comb
  begin
    for (int i = 0; i < `PAT_ENTRIES; i++)
    begin
      next_mem[i] = mem[i];
    end
    if (tbl.inc_en)
    begin
      next_mem[tbl.inc_idx] = bump_timer(mem[tbl.inc_idx]);
    end
    // a translation clears the timer anyway, so its write wins
    if (tbl.wr_en)
    begin
      next_mem[tbl.wr_idx] = tbl.wr_data;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `PAT_ENTRIES; i++)
      begin
        mem[i] <= `PAT_RST_ENTRY;
      end
    end
    else
    begin
      for (int i = 0; i < `PAT_ENTRIES; i++)
      begin
        mem[i] <= next_mem[i];
      end
    end
  end
endmodule

//--- rtl/pat_tbl_if.sv
interface pat_tbl_if;
  pat_pkg::pat_idx_t rd_idx;
  pat_pkg::pat_entry_t rd_data;
  logic wr_en;
  pat_pkg::pat_idx_t wr_idx;
  pat_pkg::pat_entry_t wr_data;
  logic inc_en;
  pat_pkg::pat_idx_t inc_idx;
  modport user (output rd_idx, input rd_data, output wr_en, output wr_idx, output wr_data,
                output inc_en, output inc_idx);
  modport table_side (input rd_idx, output rd_data, input wr_en, input wr_idx, input wr_data,
                      input inc_en, input inc_idx);
endinterface

//--- rtl/pat_top.sv
`include "pat_cfg.svh"
module pat_top (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // processor address and mode
  input wire logic [15:0] logical_addr,
  input wire logic translate_req,
  input wire logic write_flag,
  input wire logic user_mode_flag,
  // table and window commands
  input wire logic segment_load_request_n,
  input wire logic segment_store_cmd,
  input wire logic external_reg_write_cmd,
  input wire logic word_strobe,
  input wire logic [15:0] data_in,
  // translated side
  output pat_pkg::pat_paddr_t phys_addr,
  output logic mem_strobe,
  output logic protection_fault_n,
  // word transfer answers
  output logic word_ack,
  output logic window_ack,
  output pat_pkg::pat_entry_t data_out,
  // status
  output logic window_loaded
);
  // pin synchronisers
  logic [6:0] ctl_s1;
  logic [6:0] ctl_s2;
  logic [6:0] ctl_d;
  logic [15:0] addr_s1;
  logic [15:0] addr_s2;
  logic [15:0] din_s1;
  logic [15:0] din_s2;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_s1 <= 7'h08;
      ctl_s2 <= 7'h08;
      ctl_d <= 7'h08;
      addr_s1 <= 16'h0000;
      addr_s2 <= 16'h0000;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end
    else
    begin
      ctl_s1 <= {translate_req, write_flag, user_mode_flag, segment_load_request_n,
                 segment_store_cmd, external_reg_write_cmd, word_strobe};
      ctl_s2 <= ctl_s1;
      ctl_d <= ctl_s2;
      addr_s1 <= logical_addr;
      addr_s2 <= addr_s1;
      din_s1 <= data_in;
      din_s2 <= din_s1;
    end
  end

  logic xl_q;
  logic wr_q;
  logic user_q;
  logic load_n_q;
  logic store_q;
  logic wcmd_q;
  logic strobe_q;
  logic xl_rise;
  logic load_fall;
  logic store_rise;
  logic wcmd_rise;
  logic strobe_rise;
  logic strobe_fall;

  assign xl_q = ctl_s2[6];
  assign wr_q = ctl_s2[5];
  assign user_q = ctl_s2[4];
  assign load_n_q = ctl_s2[3];
  assign store_q = ctl_s2[2];
  assign wcmd_q = ctl_s2[1];
  assign strobe_q = ctl_s2[0];
  assign xl_rise = xl_q && !ctl_d[6];
  assign load_fall = !load_n_q && ctl_d[3];
  assign store_rise = store_q && !ctl_d[2];
  assign wcmd_rise = wcmd_q && !ctl_d[1];
  assign strobe_rise = strobe_q && !ctl_d[0];
  assign strobe_fall = !strobe_q && ctl_d[0];

  // fault decision for one entry
  function automatic logic prot_fault(input pat_pkg::pat_entry_t e, input logic user,
                                      input logic wr);
    prot_fault = user && (e[`PAT_SYS_BIT] || (wr && e[`PAT_RO_BIT]));
  endfunction

  pat_tbl_if tbl ();

  logic tick;
  logic bump;
  pat_pkg::pat_idx_t bump_idx;

  pat_table u_table (
    .clock(clock),
    .rstn(rstn),
    .tbl(tbl.table_side)
  );

  pat_interval u_interval (
    .clock(clock),
    .rstn(rstn),
    .load_en(wcmd_rise),
    .load_value(din_s2[7:0]),
    .tick(tick),
    .bump(bump),
    .bump_idx(bump_idx),
    .armed(window_loaded)
  );

  pat_pkg::pat_state_t state;
  pat_pkg::pat_idx_t pos;
  pat_pkg::pat_state_t next_state;
  pat_pkg::pat_idx_t next_pos;
  pat_pkg::pat_paddr_t next_phys_addr;
  logic next_mem_strobe;
  logic next_protection_fault_n;
  logic next_word_ack;
  logic next_window_ack;
  pat_pkg::pat_entry_t next_data_out;
  pat_pkg::pat_entry_t upd;
  logic fault;

  assign tbl.inc_en = bump;
  assign tbl.inc_idx = bump_idx;
  // store walks the table, everything else looks up the logical page
  assign tbl.rd_idx = (state == pat_pkg::pat_store) ? pos : addr_s2[15:12];
  assign fault = prot_fault(tbl.rd_data, user_q, wr_q);

  always_comb
  begin
    next_state = state;
    next_pos = pos;
    next_phys_addr = phys_addr;
    next_mem_strobe = mem_strobe;
    next_protection_fault_n = protection_fault_n;
    next_word_ack = word_ack;
    next_data_out = data_out;
    next_window_ack = window_ack;
    tbl.wr_en = 1'b0;
    tbl.wr_idx = pos;
    tbl.wr_data = din_s2;
    tick = 1'b0;
    upd = tbl.rd_data;
    upd[`PAT_TMR_LSB +: `PAT_TMR_W] = 6'h00;
    if (wr_q)
    begin
      upd[`PAT_MOD_BIT] = 1'b1;
    end
    if (wcmd_rise)
    begin
      next_window_ack = 1'b1;
    end
    else if (!wcmd_q)
    begin
      next_window_ack = 1'b0;
    end
    case (state)
      pat_pkg::pat_idle:
      begin
        if (load_fall)
        begin
          next_state = pat_pkg::pat_load;
          next_pos = 4'h0;
          next_word_ack = 1'b0;
        end
        else if (store_rise)
        begin
          next_state = pat_pkg::pat_store;
          next_pos = 4'h0;
          next_word_ack = 1'b0;
        end
        else if (xl_rise)
        begin
          next_state = pat_pkg::pat_xlate;
          next_phys_addr = {tbl.rd_data[`PAT_PAGE_LSB +: `PAT_PAGE_W],
                            addr_s2[`PAT_OFS_W-1:0]};
          if (fault)
          begin
            next_protection_fault_n = 1'b0;
            next_mem_strobe = 1'b0;
          end
          else
          begin
            next_mem_strobe = 1'b1;
            tbl.wr_en = 1'b1;
            tbl.wr_idx = addr_s2[15:12];
            tbl.wr_data = upd;
            tick = 1'b1;
          end
        end
      end
      pat_pkg::pat_load:
      begin
        if (strobe_rise)
        begin
          tbl.wr_en = 1'b1;
          tbl.wr_idx = pos;
          tbl.wr_data = din_s2;
          next_pos = pos + 4'h1;
          next_word_ack = 1'b1;
        end
        else if (strobe_fall)
        begin
          next_word_ack = 1'b0;
        end
        else if (load_n_q)
        begin
          next_state = pat_pkg::pat_idle;
          next_word_ack = 1'b0;
        end
      end
      pat_pkg::pat_store:
      begin
        if (strobe_rise)
        begin
          next_data_out = tbl.rd_data;
          next_pos = pos + 4'h1;
          next_word_ack = 1'b1;
        end
        else if (strobe_fall)
        begin
          next_word_ack = 1'b0;
        end
        else if (!store_q)
        begin
          next_state = pat_pkg::pat_idle;
          next_word_ack = 1'b0;
        end
      end
      pat_pkg::pat_xlate:
      begin
        // strobe and fault stand until the processor drops its request
        if (!xl_q)
        begin
          next_state = pat_pkg::pat_idle;
          next_mem_strobe = 1'b0;
          next_protection_fault_n = 1'b1;
        end
      end
      default:
      begin
        next_state = pat_pkg::pat_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= pat_pkg::pat_idle;
      pos <= 4'h0;
      phys_addr <= 18'h00000;
      mem_strobe <= 1'b0;
      protection_fault_n <= 1'b1;
      word_ack <= 1'b0;
      window_ack <= 1'b0;
      data_out <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      pos <= next_pos;
      phys_addr <= next_phys_addr;
      mem_strobe <= next_mem_strobe;
      protection_fault_n <= next_protection_fault_n;
      word_ack <= next_word_ack;
      window_ack <= next_window_ack;
      data_out <= next_data_out;
    end
  end
endmodule

//--- test/paged_address_translator_bench.sv
module paged_address_translator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] logical_addr = 16'h0000;
  logic [15:0] data_in = 16'h0000;
  logic translate_req = 1'b0;
  logic write_flag = 1'b0;
  logic user_mode_flag = 1'b0;
  logic segment_load_request_n = 1'b1;
  logic segment_store_cmd = 1'b0;
  logic external_reg_write_cmd = 1'b0;
  logic word_strobe = 1'b0;
  pat_pkg::pat_paddr_t phys_addr;
  pat_pkg::pat_paddr_t last_addr;
  pat_pkg::pat_entry_t data_out;
  logic mem_strobe, protection_fault_n, word_ack, window_ack, window_loaded;
  pat_pkg::pat_entry_t exp_tbl [16];
  logic [7:0] win, cnt;
  logic [3:0] ptr = 4'h0;
  logic win_on = 1'b0;
  logic first = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;

  always #2.5 clock = ~clock;

  pat_top dut_u (.clock, .rstn, .logical_addr, .translate_req, .write_flag, .user_mode_flag,
    .segment_load_request_n, .segment_store_cmd, .external_reg_write_cmd, .word_strobe,
    .data_in, .phys_addr, .mem_strobe, .protection_fault_n, .word_ack, .window_ack, .data_out,
    .window_loaded);
  pat_mem_model mem_u (.clock, .mem_strobe, .phys_addr, .last_addr);

  task go(input int n);
    repeat (n) @(posedge clock);
  endtask

  task chk(input logic [17:0] seen, input logic [17:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task xl(input logic [3:0] pg, input logic w, input logic u);
    logic [15:0] a;
    logic ok;
    a = {pg, 4'h5, pg, ~pg};
    ok = !(u && (exp_tbl[pg][6] || (w && exp_tbl[pg][7])));
    logical_addr <= a;
    write_flag <= w;
    user_mode_flag <= u;
    translate_req <= 1'b1;
    go(5);
    chk(18'(mem_strobe), 18'(ok));
    chk(18'(protection_fault_n), 18'(ok));
    if (ok)
      chk(last_addr, {exp_tbl[pg][5:0], a[11:0]});
    translate_req <= 1'b0;
    go(6);
    if (ok)
    begin
      exp_tbl[pg][14:8] = {6'h00, exp_tbl[pg][8] | w};
      if (win_on)
      begin
        cnt = first ? ~win : cnt + 8'h01;
        if (!first && cnt == 8'hff)
        begin
          exp_tbl[ptr][14:9] = exp_tbl[ptr][14:9] + 6'h01;
          ptr = ptr + 4'h1;
          cnt = ~win;
        end
        first = 1'b0;
      end
    end
  endtask

  task word(input logic [15:0] d, output logic [15:0] q);
    data_in <= d;
    go(4);
    word_strobe <= 1'b1;
    go(5);
    chk(18'(word_ack), 18'h00001);
    q = data_out;
    word_strobe <= 1'b0;
    go(5);
  endtask

  task t_load();
    logic [15:0] q;
    for (int k = 0; k < 16; k++)
      exp_tbl[k] = {8'h00, k == 5, k == 3, 6'(k * 3 + 17)};
    segment_load_request_n <= 1'b0;
    go(5);
    for (int k = 0; k < 16; k++)
      word(exp_tbl[k], q);
    segment_load_request_n <= 1'b1;
    go(5);
    for (int k = 0; k < 16; k++)
      xl(4'(k), 1'b0, 1'b0);
    $display("t_load done");
  endtask

  task t_prot();
    // system area is addressed directly: no request, so no memory start
    logical_addr <= 16'h0123;
    go(5);
    chk(18'(mem_strobe), 18'h00000);
    xl(4'h3, 1'b0, 1'b1);
    xl(4'h5, 1'b1, 1'b1);
    xl(4'h5, 1'b0, 1'b1);
    xl(4'h5, 1'b1, 1'b0);
    xl(4'h7, 1'b1, 1'b1);
    $display("t_prot done");
  endtask

  task t_store();
    logic [15:0] q;
    segment_store_cmd <= 1'b1;
    go(5);
    for (int k = 0; k < 16; k++)
    begin
      word(16'h0000, q);
      chk(18'(q), 18'(exp_tbl[k]));
    end
    segment_store_cmd <= 1'b0;
    go(5);
    $display("t_store done");
  endtask

  task t_timer();
    chk(18'(window_loaded), 18'h00000);
    data_in <= 16'h0002;
    external_reg_write_cmd <= 1'b1;
    go(5);
    chk(18'({window_ack, window_loaded}), 18'h00003);
    external_reg_write_cmd <= 1'b0;
    go(5);
    win = 8'h02;
    win_on = 1'b1;
    first = 1'b1;
    repeat (35) xl(4'hf, 1'b0, 1'b1);
    $display("t_timer done");
  endtask

  task wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    go(10);
    rstn <= 1'b1;
    go(2);
    t_load();
    t_prot();
    t_store();
    t_timer();
    t_store();
    wrap_up();
  end
endmodule

//--- test/pat_mem_model.sv
module pat_mem_model (
  // clock
  input wire logic clock,
  // memory start from the translator
  input wire logic mem_strobe,
  input wire pat_pkg::pat_paddr_t phys_addr,
  // word address of the last access opened
  output pat_pkg::pat_paddr_t last_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen = 1'b0;
  // memory takes the full physical address on each start
  always @(posedge clock)
  begin
    seen <= mem_strobe;
    if (mem_strobe && !seen)
      last_addr <= phys_addr;
  end
endmodule

//--- test/pat_top_chk.sv
module pat_top_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // watched inputs
  input wire logic [15:0] logical_addr,
  input wire logic translate_req,
  input wire logic user_mode_flag,
  input wire logic word_strobe,
  input wire logic external_reg_write_cmd,
  // watched outputs
  input wire pat_pkg::pat_paddr_t phys_addr,
  input wire logic mem_strobe,
  input wire logic protection_fault_n,
  input wire logic word_ack,
  input wire logic window_ack,
  input wire logic window_loaded
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_off;
    $rose(mem_strobe) |-> phys_addr[11:0] == $past(logical_addr[11:0], 3);
  endproperty
  a_off: assert property (p_off) else $error("offset changed");
  property p_req;
    $rose(mem_strobe) |-> $past(translate_req, 3);
  endproperty
  a_req: assert property (p_req) else $error("strobe without request");
  property p_blk;
    !protection_fault_n |-> !mem_strobe;
  endproperty
  a_blk: assert property (p_blk) else $error("strobe during fault");
  property p_usr;
    $fell(protection_fault_n) |-> $past(user_mode_flag, 3) && $past(translate_req, 3);
  endproperty
  a_usr: assert property (p_usr) else $error("fault outside user mode");
  property p_hold;
    $fell(protection_fault_n) |=> !protection_fault_n [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("fault too short");
  property p_rel;
    $fell(translate_req) |-> ##[1:6] (!mem_strobe && protection_fault_n);
  endproperty
  a_rel: assert property (p_rel) else $error("access not released");
  property p_ack;
    $rose(word_strobe) |-> ##[1:6] word_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("word not answered");
  property p_win;
    $rose(external_reg_write_cmd) |-> ##[1:6] (window_ack && window_loaded);
  endproperty
  a_win: assert property (p_win) else $error("window not taken");
  property p_keep;
    window_loaded |=> window_loaded;
  endproperty
  a_keep: assert property (p_keep) else $error("window flag lost");
endmodule

bind pat_top pat_top_chk chk_u (.clock, .rstn, .logical_addr, .translate_req,
  .user_mode_flag, .word_strobe, .external_reg_write_cmd, .phys_addr, .mem_strobe,
  .protection_fault_n, .word_ack, .window_ack, .window_loaded);
